/* File: rtl/lim_dir.sv */
// Purpose: Direction gate applying the cw/ccw permit table to a torque demand
// Assumes: Signed demand; zero magnitude, or not exactly one permit, gives zero
// Notes:   Registered result, one cycle of latency
`timescale 1ns/10ps
module lim_dir
	import lim_pkg::*;
(
	input  wire logic                mclk,
	input  wire logic                rstn,
	input  wire logic                cw_permit,
	input  wire logic                ccw_permit,
	input  wire lim_pkg::trq_t       demand,
	output lim_pkg::trq_t            gated
);
	trq_t gatedD;
	trq_t mag;

	always_comb begin
		mag = (demand < 0) ? -demand : demand;
		unique case ({ccw_permit, cw_permit})
			2'b01:   gatedD = demand;
			2'b10:   gatedD = -demand;
			default: gatedD = TRQ_RST;
		endcase
		if (mag == TRQ_RST) gatedD = TRQ_RST;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) gated <= TRQ_RST;
		else gated <= gatedD;
	end
endmodule : lim_dir

/* File: rtl/lim_if.sv */
// Purpose: Carries clamped limits from the bus slave to the limit core
// Assumes: Single clock domain
// Notes:   Bank arrays indexed by group code
`timescale 1ns/10ps
interface lim_if;
	import lim_pkg::*;
	spd_t intPos [4];
	spd_t intNeg [4];
	pct_t intUp  [4];
	pct_t intLo  [4];
	spd_t ovrPos;
	spd_t ovrNeg;
	trq_t ovrUp;
	trq_t ovrLo;
	spd_t hyst;
	spd_t vmax;
	spd_t srTh;
	trq_t rated;
	modport regs (output intPos, intNeg, intUp, intLo, ovrPos, ovrNeg, ovrUp, ovrLo, hyst, vmax, srTh, rated);
	modport core (input intPos, intNeg, intUp, intLo, ovrPos, ovrNeg, ovrUp, ovrLo, hyst, vmax, srTh, rated);
endinterface : lim_if

/* File: rtl/lim_pkg.sv */
// Purpose: Shared constants and types for the servo limit select and monitor block
// Assumes: Speeds in rpm, torques in 0.01 Nm, percents in whole percent, all signed
// Notes:   APB register map, field layouts and reset values live here
package lim_pkg;
	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int SPD_W = 20;
	localparam int TRQ_W = 32;
	localparam int PCT_W = 12;
	localparam int ADC_W = 16;
	localparam int ADDR_W = 12;
	typedef logic signed [SPD_W-1:0] spd_t;
	typedef logic signed [TRQ_W-1:0] trq_t;
	typedef logic signed [PCT_W-1:0] pct_t;

	// ----------------------------------------
	// Limits and reset values
	// ----------------------------------------
	localparam spd_t SPD_MAX = 20'sd210000;
	localparam spd_t SPD_MIN = -20'sd210000;
	localparam pct_t UPCT_MAX = 12'sd350;
	localparam pct_t UPCT_MIN = -12'sd150;
	localparam pct_t LPCT_MAX = 12'sd150;
	localparam pct_t LPCT_MIN = -12'sd350;
	// Overall torque limits in 0.01 Nm
	localparam trq_t OUP_MAX = 32'sd2000000000;
	localparam trq_t OUP_MIN = -32'sd100000000;
	localparam trq_t OLO_MAX = 32'sd100000000;
	localparam trq_t OLO_MIN = -32'sd2000000000;
	localparam trq_t TRQ_RST = 32'sd0;
	localparam spd_t HYST_RST = 20'sd0;
	localparam spd_t VMAX_RST = 20'sd3000;
	localparam spd_t SRTH_RST = 20'sd10;
	localparam trq_t RATED_RST = 32'sd100;
	// Torque-limit-reached band, 0.01 Nm
	localparam trq_t TLR_BAND = 32'sd50;
	// Full-scale analog code for 10 V
	localparam int ADC_FS = 16'sd10000;

	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [ADDR_W-1:0] A_INT_POS = 12'h000;
	localparam logic [ADDR_W-1:0] A_INT_NEG = 12'h010;
	localparam logic [ADDR_W-1:0] A_INT_UPT = 12'h020;
	localparam logic [ADDR_W-1:0] A_INT_LOT = 12'h030;
	localparam logic [ADDR_W-1:0] A_OVR_POS = 12'h040;
	localparam logic [ADDR_W-1:0] A_OVR_NEG = 12'h044;
	localparam logic [ADDR_W-1:0] A_OVR_UPT = 12'h048;
	localparam logic [ADDR_W-1:0] A_OVR_LOT = 12'h04C;
	localparam logic [ADDR_W-1:0] A_HYST = 12'h050;
	localparam logic [ADDR_W-1:0] A_VMAX = 12'h054;
	localparam logic [ADDR_W-1:0] A_SRTH = 12'h058;
	localparam logic [ADDR_W-1:0] A_RATED = 12'h05C;
	localparam logic [ADDR_W-1:0] A_MOTMAX = 12'h060;
	localparam logic [ADDR_W-1:0] A_STATUS = 12'h064;
	localparam int ST_SPEED_REACHED_FLAG = 0;
	localparam int ST_TLR = 1;
	localparam int ST_OVS = 2;
	localparam int ST_OVT = 3;
	localparam int ST_SSEL = 4;
	localparam int ST_TSEL = 6;
endpackage : lim_pkg

/* File: rtl/lim_regs.sv */
// Purpose: APB register file holding all limit parameters
// Assumes: Zero-wait APB; writes clamped into the legal range
// Notes:   Commissioning pulse loads motor max speed into all speed limits
`timescale 1ns/10ps
module lim_regs
	import lim_pkg::*;
(
	input  wire logic                      mclk,
	input  wire logic                      rstn,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [lim_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]               pwdata,
	input  wire logic                      commissionDone,
	lim_if.regs                            lim
);
	spd_t posQ [4], posD [4], negQ [4], negD [4];
	pct_t upQ [4], upD [4], loQ [4], loD [4];
	spd_t ovrPosQ, ovrPosD, ovrNegQ, ovrNegD, hystQ, hystD, vmaxQ, vmaxD, srThQ, srThD, motMaxQ, motMaxD;
	trq_t ovrUpQ, ovrUpD, ovrLoQ, ovrLoD, ratedQ, ratedD;
	logic wr;

	function automatic spd_t clampS(input logic [31:0] v, input spd_t lo, input spd_t hi);
		logic signed [31:0] s;
		s = signed'(v);
		if (s < 32'(lo)) return lo;
		if (s > 32'(hi)) return hi;
		return spd_t'(s[SPD_W-1:0]);
	endfunction : clampS

	function automatic pct_t clampP(input logic [31:0] v, input pct_t lo, input pct_t hi);
		logic signed [31:0] s;
		s = signed'(v);
		if (s < 32'(lo)) return lo;
		if (s > 32'(hi)) return hi;
		return pct_t'(s[PCT_W-1:0]);
	endfunction : clampP

	function automatic trq_t clampT(input logic [31:0] v, input trq_t lo, input trq_t hi);
		trq_t s;
		s = signed'(v);
		if (s < lo) return lo;
		if (s > hi) return hi;
		return s;
	endfunction : clampT

	assign wr = psel & penable & pwrite;

	always_comb begin
		posD = posQ;
		negD = negQ;
		upD = upQ;
		loD = loQ;
		ovrPosD = ovrPosQ;
		ovrNegD = ovrNegQ;
		ovrUpD = ovrUpQ;
		ovrLoD = ovrLoQ;
		hystD = hystQ;
		vmaxD = vmaxQ;
		srThD = srThQ;
		ratedD = ratedQ;
		motMaxD = motMaxQ;
		if (wr) begin
			for (int i = 0; i < 4; i++) begin
				if (paddr == A_INT_POS + ADDR_W'(4*i)) posD[i] = clampS(pwdata, 20'sd0, SPD_MAX);
				if (paddr == A_INT_NEG + ADDR_W'(4*i)) negD[i] = clampS(pwdata, SPD_MIN, 20'sd0);
				if (paddr == A_INT_UPT + ADDR_W'(4*i)) upD[i] = clampP(pwdata, UPCT_MIN, UPCT_MAX);
				if (paddr == A_INT_LOT + ADDR_W'(4*i)) loD[i] = clampP(pwdata, LPCT_MIN, LPCT_MAX);
			end
			if (paddr == A_OVR_POS) ovrPosD = clampS(pwdata, 20'sd0, SPD_MAX);
			if (paddr == A_OVR_NEG) ovrNegD = clampS(pwdata, SPD_MIN, 20'sd0);
			if (paddr == A_OVR_UPT) ovrUpD = clampT(pwdata, OUP_MIN, OUP_MAX);
			if (paddr == A_OVR_LOT) ovrLoD = clampT(pwdata, OLO_MIN, OLO_MAX);
			if (paddr == A_HYST) hystD = clampS(pwdata, 20'sd0, SPD_MAX);
			if (paddr == A_VMAX) vmaxD = clampS(pwdata, 20'sd0, SPD_MAX);
			if (paddr == A_SRTH) srThD = clampS(pwdata, 20'sd0, SPD_MAX);
			if (paddr == A_RATED) ratedD = clampT(pwdata, 32'sd0, OUP_MAX);
			if (paddr == A_MOTMAX) motMaxD = clampS(pwdata, 20'sd0, SPD_MAX);
		end
		if (commissionDone) begin
			for (int i = 0; i < 4; i++) begin
				posD[i] = motMaxQ;
				negD[i] = -motMaxQ;
			end
			ovrPosD = motMaxQ;
			ovrNegD = -motMaxQ;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < 4; i++) begin
				posQ[i] <= SPD_MAX;
				negQ[i] <= SPD_MIN;
				upQ[i] <= UPCT_MAX;
				loQ[i] <= LPCT_MIN;
			end
			ovrPosQ <= SPD_MAX;
			ovrNegQ <= SPD_MIN;
			ovrUpQ <= TRQ_RST;
			ovrLoQ <= TRQ_RST;
			hystQ <= HYST_RST;
			vmaxQ <= VMAX_RST;
			srThQ <= SRTH_RST;
			ratedQ <= RATED_RST;
			motMaxQ <= SPD_MAX;
		end else begin
			posQ <= posD;
			negQ <= negD;
			upQ <= upD;
			loQ <= loD;
			ovrPosQ <= ovrPosD;
			ovrNegQ <= ovrNegD;
			ovrUpQ <= ovrUpD;
			ovrLoQ <= ovrLoD;
			hystQ <= hystD;
			vmaxQ <= vmaxD;
			srThQ <= srThD;
			ratedQ <= ratedD;
			motMaxQ <= motMaxD;
		end
	end

	assign lim.intPos = posQ;
	assign lim.intNeg = negQ;
	assign lim.intUp = upQ;
	assign lim.intLo = loQ;
	assign lim.ovrPos = ovrPosQ;
	assign lim.ovrNeg = ovrNegQ;
	assign lim.ovrUp = ovrUpQ;
	assign lim.ovrLo = ovrLoQ;
	assign lim.hyst = hystQ;
	assign lim.vmax = vmaxQ;
	assign lim.srTh = srThQ;
	assign lim.rated = ratedQ;
endmodule : lim_regs

/* File: rtl/servo_limit_select_monitor.sv */
// Purpose: Limit selection, clamping and monitoring for a servo drive
// Assumes: Speeds rpm, torques 0.01 Nm, analog codes with 10 V at full scale
// Notes:   All outputs registered; APB zero-wait, unmapped reads give zero
//
// Behaviour
// - Cw permit keeps sign, ccw inverts, neither, both or zero input gives zero.
// - Two-bit speed code picks internal speed group, changeable while running.
// - Overall speed limits apply together with the selected group.
// - Overspeed fault beyond positive limit plus hysteresis or negative minus it.
// - Internal speed limits span 0..210000 and -210000..0, defaults at extremes.
// - Speed code 0-1 uses analog input 0 scaled to max speed reference.
// - Overall speed limits span 0..210000 and -210000..0, defaults at extremes.
// - Commissioning done loads motor max speed into all speed limits.
// - Speed-reached flag while actual speed is inside threshold window.
// - Two-bit torque code picks internal torque group, changeable while running.
// - Overall torque limits apply together with the selected group.
// - Upper torque percent -150..350, lower -350..150, defaults 350 and -350.
// - Torque code 0-1 uses analog input 1 scaled to rated torque as upper limit only.
// - Delivered torque saturates at the selected limit.
// - Quick stop switches to overall limits at maximum braking torque.
// - Overall torque limits span given ranges, both reset to zero.
// - Limit-reached flag when torque nears upper, lower or analog limit.
`timescale 1ns/10ps
module servo_limit_select_monitor
	import lim_pkg::*;
(
	input  wire logic                       mclk,
	input  wire logic                       rstn,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [lim_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]                pwdata,
	output logic [31:0]                     prdata,
	output logic                            pready,
	output logic                            pslverr,
	input  wire logic                       cw_permit,
	input  wire logic                       ccw_permit,
	input  wire logic                       spd_lim_sel_lo,
	input  wire logic                       spd_lim_sel_hi,
	input  wire logic                       trq_lim_sel_lo,
	input  wire logic                       trq_lim_sel_hi,
	input  wire logic                       quick_stop,
	input  wire logic                       commissionDone,
	input  wire logic signed [lim_pkg::ADC_W-1:0] analogIn0,
	input  wire logic signed [lim_pkg::ADC_W-1:0] analogIn1,
	input  wire lim_pkg::spd_t              actualSpeed,
	input  wire lim_pkg::trq_t              motorTorque,
	input  wire lim_pkg::trq_t              torqueSetpoint,
	output lim_pkg::trq_t                   torqueOut,
	output lim_pkg::spd_t                   speedLimPos,
	output lim_pkg::spd_t                   speedLimNeg,
	output logic                            speed_reached_flag,
	output logic                            torque_limit_hit_flag,
	output logic                            overspeed_fault,
	output logic                            overtorque_fault
);
	// ----------------------------------------
	// Register file and direction gate
	// ----------------------------------------
	lim_if lim ();
	trq_t gatedSet;
	logic [1:0] sSel, tSel;
	logic rdHit;
	logic [31:0] rdData;

	lim_regs uRegs (
		.mclk           (mclk),
		.rstn           (rstn),
		.psel           (psel),
		.penable        (penable),
		.pwrite         (pwrite),
		.paddr          (paddr),
		.pwdata         (pwdata),
		.commissionDone (commissionDone),
		.lim            (lim)
	);

	lim_dir uDir (
		.mclk       (mclk),
		.rstn       (rstn),
		.cw_permit  (cw_permit),
		.ccw_permit (ccw_permit),
		.demand     (torqueSetpoint),
		.gated      (gatedSet)
	);

	assign sSel = {spd_lim_sel_hi, spd_lim_sel_lo};
	assign tSel = {trq_lim_sel_hi, trq_lim_sel_lo};

	// ----------------------------------------
	// Limit computation
	// ----------------------------------------
	spd_t posLim, negLim, hiTrip, loTrip;
	trq_t upLim, loLim, grpUp, grpLo, clamped, bandUp, bandLo;
	logic signed [47:0] anaSpd, anaTrq, pctUp, pctLo;
	logic overSpd, overTrq, inWin, nearLim;

	always_comb begin
		anaSpd = 48'(analogIn0) * 48'(lim.vmax) / 48'(ADC_FS);
		anaTrq = 48'(analogIn1) * 48'(lim.rated) / 48'(ADC_FS);
		pctUp = 48'(lim.intUp[tSel]) * 48'(lim.rated) / 48'sd100;
		pctLo = 48'(lim.intLo[tSel]) * 48'(lim.rated) / 48'sd100;
		posLim = lim.intPos[sSel];
		negLim = lim.intNeg[sSel];
		if (sSel == 2'b01) begin
			posLim = (anaSpd < 0) ? -spd_t'(anaSpd[SPD_W-1:0]) : spd_t'(anaSpd[SPD_W-1:0]);
			negLim = -posLim;
		end
		if (posLim > lim.ovrPos) posLim = lim.ovrPos;
		if (negLim < lim.ovrNeg) negLim = lim.ovrNeg;
		grpUp = trq_t'(pctUp[TRQ_W-1:0]);
		grpLo = trq_t'(pctLo[TRQ_W-1:0]);
		if (tSel == 2'b01) grpUp = trq_t'(anaTrq[TRQ_W-1:0]);
		upLim = grpUp;
		loLim = grpLo;
		if (upLim > lim.ovrUp) upLim = lim.ovrUp;
		if (loLim < lim.ovrLo) loLim = lim.ovrLo;
		if (quick_stop) begin
			upLim = lim.ovrUp;
			loLim = lim.ovrLo;
		end
		clamped = gatedSet;
		if (clamped > upLim) clamped = upLim;
		if (clamped < loLim) clamped = loLim;
		if (gatedSet == TRQ_RST) clamped = TRQ_RST;
		if (quick_stop) clamped = (actualSpeed > 0) ? loLim : ((actualSpeed < 0) ? upLim : TRQ_RST);
		hiTrip = posLim + lim.hyst;
		loTrip = negLim - lim.hyst;
		overSpd = (actualSpeed > hiTrip) || (actualSpeed < loTrip);
		overTrq = (motorTorque > grpUp) || (motorTorque < grpLo);
		inWin = (actualSpeed <= lim.srTh) && (actualSpeed >= -lim.srTh);
		bandUp = upLim - TLR_BAND;
		bandLo = loLim + TLR_BAND;
		nearLim = (motorTorque >= bandUp) || (motorTorque <= bandLo);
	end

	// ----------------------------------------
	// APB read decode
	// ----------------------------------------
	always_comb begin
		rdHit = 1'b1;
		rdData = 32'h0000_0000;
		unique case (paddr)
			A_OVR_POS: rdData = 32'(lim.ovrPos);
			A_OVR_NEG: rdData = 32'(lim.ovrNeg);
			A_OVR_UPT: rdData = lim.ovrUp;
			A_OVR_LOT: rdData = lim.ovrLo;
			A_HYST:    rdData = 32'(lim.hyst);
			A_VMAX:    rdData = 32'(lim.vmax);
			A_SRTH:    rdData = 32'(lim.srTh);
			A_RATED:   rdData = lim.rated;
			A_MOTMAX:  rdData = 32'h0000_0000;
			A_STATUS:  rdData = {24'h00_0000, tSel, sSel, overtorque_fault, overspeed_fault,
				torque_limit_hit_flag, speed_reached_flag};
			default: begin
				rdHit = 1'b0;
				for (int i = 0; i < 4; i++) begin
					if (paddr == A_INT_POS + ADDR_W'(4*i)) begin
						rdData = 32'(lim.intPos[i]);
						rdHit = 1'b1;
					end
					if (paddr == A_INT_NEG + ADDR_W'(4*i)) begin
						rdData = 32'(lim.intNeg[i]);
						rdHit = 1'b1;
					end
					if (paddr == A_INT_UPT + ADDR_W'(4*i)) begin
						rdData = 32'(lim.intUp[i]);
						rdHit = 1'b1;
					end
					if (paddr == A_INT_LOT + ADDR_W'(4*i)) begin
						rdData = 32'(lim.intLo[i]);
						rdHit = 1'b1;
					end
				end
			end
		endcase
	end

	// ----------------------------------------
	// Output registers
	// ----------------------------------------
	logic [31:0] prdataD;
	logic pslverrD;
	// Unmapped reads return zero, error flagged for any unmapped access
	always_comb begin
		prdataD = (psel && !penable && !pwrite) ? rdData : prdata;
		pslverrD = psel && !penable && !rdHit;
		if (psel && penable) pslverrD = pslverr;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			torqueOut <= TRQ_RST;
			speedLimPos <= SPD_MAX;
			speedLimNeg <= SPD_MIN;
			speed_reached_flag <= 1'b0;
			torque_limit_hit_flag <= 1'b0;
			overspeed_fault <= 1'b0;
			overtorque_fault <= 1'b0;
		end else begin
			prdata <= prdataD;
			pready <= psel & ~penable;
			pslverr <= pslverrD;
			torqueOut <= clamped;
			speedLimPos <= posLim;
			speedLimNeg <= negLim;
			speed_reached_flag <= inWin;
			torque_limit_hit_flag <= nearLim;
			overspeed_fault <= overSpd;
			overtorque_fault <= overTrq;
		end
	end
endmodule : servo_limit_select_monitor

/* File: verification/host_ctrl_model.sv */
// Purpose: Host controller model driving the command pins
// Assumes: Bench hands over commands, pins follow one edge later
// Notes:   Pins change only right after a rising edge, or at once when rstn falls
`timescale 1ns/10ps
module host_ctrl_model (
	input  wire logic       mclk,
	input  wire logic       rstn,
	input  wire logic [1:0] dirCmd,
	input  wire logic [1:0] spdCmd,
	input  wire logic [1:0] trqCmd,
	input  wire logic       stopCmd,
	output logic            cw_permit,
	output logic            ccw_permit,
	output logic            spd_lim_sel_lo,
	output logic            spd_lim_sel_hi,
	output logic            trq_lim_sel_lo,
	output logic            trq_lim_sel_hi,
	output logic            quick_stop
);
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			{ccw_permit, cw_permit} <= 2'h0;
			{spd_lim_sel_hi, spd_lim_sel_lo} <= 2'h0;
			{trq_lim_sel_hi, trq_lim_sel_lo} <= 2'h0;
			quick_stop <= 1'b0;
		end else begin
			{ccw_permit, cw_permit} <= dirCmd;
			{spd_lim_sel_hi, spd_lim_sel_lo} <= spdCmd;
			{trq_lim_sel_hi, trq_lim_sel_lo} <= trqCmd;
			quick_stop <= stopCmd;
		end
	end
endmodule : host_ctrl_model

/* File: verification/servo_limit_select_monitor_bench.sv */
// Purpose: Self-checking bench for the limit block
// Assumes: Outputs settle within six cycles of a change
// Notes:   Analog torque code keeps the lower group limit
`timescale 1ns/10ps
module servo_limit_select_monitor_bench;
	import lim_pkg::*;
	logic mclk, rstn, psel, penable, pwrite, pready, pslverr, commissionDone, err, stopCmd;
	logic cw_permit, ccw_permit, spd_lim_sel_lo, spd_lim_sel_hi, trq_lim_sel_lo, trq_lim_sel_hi, quick_stop;
	logic speed_reached_flag, torque_limit_hit_flag, overspeed_fault, overtorque_fault;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] dirCmd, spdCmd, trqCmd;
	logic signed [ADC_W-1:0] analogIn0, analogIn1;
	spd_t actualSpeed, speedLimPos, speedLimNeg;
	trq_t motorTorque, torqueSetpoint, torqueOut;
	int error_cnt, n_checks, seed, i, s;
	int up[4] = '{100, 200, 300, 350};
	int lo[4] = '{-50, -100, -200, -350};
	logic [ADDR_W-1:0] tA[8] = '{12'h008, 12'h01C, 12'h024, 12'h03C, 12'h044, 12'h048, 12'h058, 12'h068};
	int tR[8] = '{210000, -210000, 350, -350, -210000, 0, 10, 0};
	int tW[8] = '{300000, 5, 400, 200, -300000, 2100000000, 20, 5};
	int tE[8] = '{210000, 0, 350, 150, -210000, 2000000000, 20, 0};
	int ovs[4] = '{1100, 1101, -600, -601};
	int ovt[4] = '{100, 101, -50, -51};

	host_ctrl_model host (.mclk, .rstn, .dirCmd, .spdCmd, .trqCmd, .stopCmd, .cw_permit, .ccw_permit,
		.spd_lim_sel_lo, .spd_lim_sel_hi, .trq_lim_sel_lo, .trq_lim_sel_hi, .quick_stop);
	servo_limit_select_monitor dut (.mclk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .cw_permit, .ccw_permit, .spd_lim_sel_lo, .spd_lim_sel_hi, .trq_lim_sel_lo,
		.trq_lim_sel_hi, .quick_stop, .commissionDone, .analogIn0, .analogIn1, .actualSpeed, .motorTorque,
		.torqueSetpoint, .torqueOut, .speedLimPos, .speedLimNeg, .speed_reached_flag, .torque_limit_hit_flag,
		.overspeed_fault, .overtorque_fault);

	// ----
	// Tasks and model
	// ----
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic checkBit(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t flag got=%h exp=%h", $time, got, exp);
		end
	endtask : checkBit
	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
	endtask : wt
	// Holds the request until ready is seen at an edge; a hang is left to the watchdog
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	function automatic int expTrq(int d, int dir, int c);
		int g, hi;
		g = (dir == 1) ? d : ((dir == 2) ? -d : 0);
		hi = (c == 1) ? 50 : ((up[c] < 250) ? up[c] : 250);
		return (g > hi) ? hi : ((g < lo[c]) ? lo[c] : g);
	endfunction : expTrq
	task automatic give_verdict;
		$display("Comparisons %0d, mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : give_verdict

	// ----
	// Clock, watchdog, sequence
	// ----
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	// Run needs under a thousand cycles
	initial begin
		wt(5000);
		error_cnt++;
		give_verdict();
	end
	initial begin
		seed = 66347;
		{rstn, psel, penable, pwrite, commissionDone, stopCmd} = 6'h0;
		{paddr, pwdata, dirCmd, spdCmd, trqCmd} = '0;
		{analogIn0, analogIn1, actualSpeed, motorTorque, torqueSetpoint} = '0;
		error_cnt = 0;
		n_checks = 0;
		wt(10);
		rstn <= 1'b1;
		check(speedLimPos, SPD_MAX);
		for (i = 0; i < 8; i++) begin
			apb(1'b0, tA[i], 32'h0);
			check(rd, tR[i]);
			apb(1'b1, tA[i], tW[i]);
			apb(1'b0, tA[i], 32'h0);
			check(rd, tE[i]);
			checkBit(err, tA[i] == 12'h068);
		end
		for (i = 0; i < 4; i++) begin
			apb(1'b1, A_INT_POS + 12'(4 * i), 1000 * (i + 1));
			apb(1'b1, A_INT_NEG + 12'(4 * i), -500 * (i + 1));
			apb(1'b1, A_INT_UPT + 12'(4 * i), up[i]);
			apb(1'b1, A_INT_LOT + 12'(4 * i), lo[i]);
		end
		apb(1'b1, A_OVR_POS, 2500);
		apb(1'b1, A_HYST, 100);
		apb(1'b1, A_OVR_UPT, 250);
		apb(1'b1, A_OVR_LOT, -100000);
		analogIn0 <= -16'sd5000;
		for (i = 0; i < 4; i++) begin
			spdCmd <= 2'(i);
			wt(6);
			s = (i == 1) ? 1500 : 1000 * (i + 1);
			check(speedLimPos, (s > 2500) ? 2500 : s);
			check(speedLimNeg, (i == 1) ? -1500 : -500 * (i + 1));
		end
		spdCmd <= 2'h0;
		for (i = 0; i < 4; i++) begin
			actualSpeed <= spd_t'(ovs[i]);
			wt(3);
			checkBit(overspeed_fault, ovs[i] > 1100 || ovs[i] < -600);
		end
		for (i = 0; i < 8; i++) begin
			s = $random(seed) % 41;
			actualSpeed <= spd_t'(s);
			wt(3);
			checkBit(speed_reached_flag, s <= 20 && s >= -20);
		end
		actualSpeed <= 20'sh0;
		analogIn1 <= 16'sd5000;
		for (i = 0; i < 16; i++) begin
			s = 100 + {$random(seed)} % 400;
			trqCmd <= 2'(i / 4);
			dirCmd <= 2'(i % 4);
			torqueSetpoint <= s;
			wt(6);
			check(torqueOut, expTrq(s, i % 4, i / 4));
		end
		analogIn1 <= 16'sd10000;
		wt(3);
		checkBit(torque_limit_hit_flag, 1'b0);
		trqCmd <= 2'h0;
		dirCmd <= 2'h1;
		torqueSetpoint <= 400;
		wt(6);
		checkBit(torque_limit_hit_flag, 1'b1);
		for (i = 0; i < 4; i++) begin
			motorTorque <= ovt[i];
			wt(3);
			checkBit(overtorque_fault, ovt[i] > 100 || ovt[i] < -50);
		end
		stopCmd <= 1'b1;
		actualSpeed <= 20'sd500;
		wt(6);
		check(torqueOut, -100000);
		actualSpeed <= -20'sd500;
		wt(6);
		check(torqueOut, 250);
		stopCmd <= 1'b0;
		apb(1'b1, A_MOTMAX, 7000);
		commissionDone <= 1'b1;
		@(posedge mclk);
		commissionDone <= 1'b0;
		wt(4);
		check(speedLimPos, 7000);
		apb(1'b0, A_INT_POS + 12'h4, 32'h0);
		check(rd, 7000);
		apb(1'b0, A_OVR_NEG, 32'h0);
		check(rd, -7000);
		apb(1'b0, A_STATUS, 32'h0);
		check(rd, 32'h0000_000A);
		give_verdict();
	end
endmodule : servo_limit_select_monitor_bench

bind servo_limit_select_monitor slsm_props chk (.mclk, .rstn, .psel, .penable, .pwrite, .paddr, .prdata,
	.pready, .pslverr, .cw_permit, .ccw_permit, .quick_stop, .actualSpeed, .torqueSetpoint, .torqueOut,
	.speedLimPos, .speedLimNeg, .speed_reached_flag, .overspeed_fault);

/* File: verification/servo_limit_select_monitor_props.sv */
// Purpose: Port-level assertions for the limit block
// Assumes: Zero-wait bus, registered outputs
// Notes:   Torque checks wait three cycles for the two-stage path
`timescale 1ns/10ps
module slsm_props
	import lim_pkg::*;
(
	input wire logic                 mclk,
	input wire logic                 rstn,
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pwrite,
	input wire logic [ADDR_W-1:0]    paddr,
	input wire logic [31:0]          prdata,
	input wire logic                 pready,
	input wire logic                 pslverr,
	input wire logic                 cw_permit,
	input wire logic                 ccw_permit,
	input wire logic                 quick_stop,
	input wire lim_pkg::spd_t        actualSpeed,
	input wire lim_pkg::trq_t        torqueSetpoint,
	input wire lim_pkg::trq_t        torqueOut,
	input wire lim_pkg::spd_t        speedLimPos,
	input wire lim_pkg::spd_t        speedLimNeg,
	input wire logic                 speed_reached_flag,
	input wire logic                 overspeed_fault
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	sequence setupPh; psel && !penable; endsequence
	sequence dirOff; (cw_permit == ccw_permit) && !quick_stop; endsequence
	sequence zeroSet; (torqueSetpoint == 0) && !quick_stop; endsequence
	AST_PREADY_SETUP: assert property (setupPh |=> pready) else $error("no ready after setup");
	AST_PREADY_ACCESS: assert property (pready |-> psel && penable ##1 !pready) else $error("stray ready");
	AST_SLVERR_MAP: assert property (pready |-> pslverr == (paddr > 12'h064 || paddr[1:0] != 2'h0))
		else $error("wrong slave error");
	AST_PRDATA_HOLD: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
		else $error("read data moved");
	AST_LIM_RANGE: assert property (speedLimPos >= 0 && speedLimPos <= SPD_MAX &&
		speedLimNeg <= 0 && speedLimNeg >= SPD_MIN) else $error("speed limit out of range");
	AST_DIR_ZERO: assert property (dirOff [*3] |=> torqueOut == 0) else $error("torque without permit");
	AST_ZERO_SET: assert property (zeroSet [*3] |=> torqueOut == 0) else $error("torque from zero");
	AST_OVERSPEED: assert property (overspeed_fault && $stable(speedLimPos) && $stable(speedLimNeg) |->
		$past(actualSpeed) > speedLimPos || $past(actualSpeed) < speedLimNeg) else $error("false overspeed");
	AST_SPEED_REACHED_FLAG_ZERO: assert property (actualSpeed == 0 |=> speed_reached_flag) else $error("no speed reached");
endmodule : slsm_props
